/* rtl/timer_h.sv */
// interval, square wave and pwm timer with its port direction register
module timer_h (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        low_speed_osc_clock,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             timer_interrupt_request,
  output logic             timer_output,
  output logic             port_pin2,
  output logic             port_pin2_oe
);
  import timer_pkg::*;

  tick_if tk ();

  logic [7:0]     timer_mode_control;
  logic [7:0]     cycle_compare;
  logic [7:0]     duty_compare;
  logic [7:0]     duty_active;
  logic [7:0]     port4_direction;
  logic [7:0]     port4_latch;
  logic [7:0]     counter;
  logic           duty_pending;
  logic [1:0]     guard_count;
  logic           start_mask;
  logic           out_state;
  compare_sel_t   compare_sel;
  logic           count_enable;
  logic [1:0]     mode;
  logic           output_default_level;
  logic           output_gate;
  logic           tick;
  logic           cycle_match;
  logic           duty_match;
  logic           duty_write;
  logic           counting;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r, input logic s);
    return s && (a == r);
  endfunction : hit

  assign count_enable         = timer_mode_control[enable_bit];
  assign mode                 = timer_mode_control[mode_hi:mode_lo];
  assign output_default_level = timer_mode_control[level_bit];
  assign output_gate          = timer_mode_control[gate_bit];
  assign tk.clock_select      = timer_mode_control[clock_sel_hi:clock_sel_lo];
  assign tk.run               = count_enable;
  assign tick                 = tk.tick && clk_en;
  assign duty_write           = hit(bus_addr, duty_compare_addr, bus_write);
  assign counting             = count_enable && tick && !start_mask;

  tick_gen u_tick_gen (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .clk_en              (clk_en),
    .low_speed_osc_clock (low_speed_osc_clock),
    .tk                  (tk)
  );

  // compares only act on a count tick; the duty compare only in pwm mode
  assign cycle_match = counting && (counter == cycle_compare)
                       && (mode != mode_pwm || compare_sel == cmp_cycle);
  assign duty_match  = counting && (mode == mode_pwm) && (compare_sel == cmp_duty)
                       && (counter == duty_active);

  // register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_control <= byte_reset;
      cycle_compare      <= byte_reset;
      port4_direction    <= port4_direction_reset;
      port4_latch        <= byte_reset;
    end else if (clk_en && bus_write) begin
      if (hit(bus_addr, timer_mode_control_addr, 1'b1)) begin
        timer_mode_control <= bus_wdata;
      end
      if (hit(bus_addr, cycle_compare_addr, 1'b1)) begin
        cycle_compare <= bus_wdata;
      end
      if (hit(bus_addr, port4_direction_addr, 1'b1)) begin
        port4_direction <= bus_wdata;
      end
      if (hit(bus_addr, port4_latch_addr, 1'b1)) begin
        port4_latch <= bus_wdata;
      end
    end
  end

  // duty compare buffer and its guarded transfer to the active copy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_compare <= byte_reset;
      duty_active  <= byte_reset;
      duty_pending <= 1'b0;
      guard_count  <= 2'd0;
    end else if (clk_en) begin
      if (duty_write) begin
        duty_compare <= bus_wdata;
        guard_count  <= 2'd0;
        if (!count_enable) begin
          duty_active  <= bus_wdata;
          duty_pending <= 1'b0;
        end else begin
          duty_pending <= 1'b1;
        end
      end else begin
        if (tick && guard_count != 2'(transfer_guard)) begin
          guard_count <= guard_count + 2'd1;
        end
        if (duty_match && duty_pending && guard_count == 2'(transfer_guard)) begin
          duty_active  <= duty_compare;
          duty_pending <= 1'b0;
        end
      end
      // a write in the match cycle leaves duty_active untouched
    end
  end

  // first count clock after enabling is masked so counting starts cleanly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_mask <= 1'b1;
    end else if (clk_en) begin
      if (!count_enable) begin
        start_mask <= 1'b1;
      end else if (tick) begin
        start_mask <= 1'b0;
      end
    end
  end

  // counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter <= byte_reset;
    end else if (clk_en) begin
      if (!count_enable) begin
        counter <= byte_reset;
      end else if (cycle_match) begin
        counter <= byte_reset;
      end else if (counting) begin
        counter <= counter + 8'd1;
      end
    end
  end

  // compare selection and output state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compare_sel <= cmp_cycle;
      out_state   <= 1'b0;
    end else if (clk_en) begin
      if (!count_enable) begin
        compare_sel <= cmp_cycle;
        out_state   <= 1'b0;
      end else if (mode == mode_pwm) begin
        if (cycle_match) begin
          out_state   <= 1'b1;
          compare_sel <= cmp_duty;
        end else if (duty_match) begin
          out_state   <= 1'b0;
          compare_sel <= cmp_cycle;
        end
      end else if (cycle_match) begin
        out_state <= !out_state;
      end
    end
  end

  // one-cycle request per cycle match, set only from a cycle with the timer enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_interrupt_request <= 1'b0;
    end else if (clk_en) begin
      timer_interrupt_request <= cycle_match && count_enable;
    end
  end

  // active level is the opposite of the default level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_output <= 1'b0;
    end else if (clk_en) begin
      if (output_gate) begin
        timer_output <= out_state ^ output_default_level;
      end else begin
        timer_output <= output_default_level;
      end
    end
  end

  // pin drives timer output only with direction and latch both zero
  assign port_pin2_oe = !port4_direction[timer_pin];
  assign port_pin2    = timer_output & !port4_latch[timer_pin];

  // read back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= byte_reset;
    end else if (clk_en && bus_read) begin
      if (hit(bus_addr, timer_mode_control_addr, 1'b1)) begin
        bus_rdata <= timer_mode_control;
      end else if (hit(bus_addr, cycle_compare_addr, 1'b1)) begin
        bus_rdata <= cycle_compare;
      end else if (hit(bus_addr, duty_compare_addr, 1'b1)) begin
        bus_rdata <= duty_compare;
      end else if (hit(bus_addr, port4_direction_addr, 1'b1)) begin
        bus_rdata <= port4_direction;
      end else if (hit(bus_addr, port4_latch_addr, 1'b1)) begin
        bus_rdata <= port4_latch;
      end else begin
        bus_rdata <= byte_reset;
      end
    end
  end
endmodule : timer_h

/* rtl/timer_pkg.sv */
// constants and types shared by the interval and pwm timer block
//
// Contract
// - compare registers byte wide, reset to zero
// - duty write while counting held until active duty match, written straight through while stopped
// - write colliding with transfer skips that transfer
// - enable bit starts counting, clearing stops and clears
// - bits 6:4 select count clock divider
// - bits 3:2 select interval or pwm mode
// - bit 1 sets inactive output level
// - bit 0 gates output, square wave in interval
// - cycle match raises request and clears counter
// - counting starts on the second count clock, the first is masked
// - interval match inverts output with the clear
// - disable forces request and output inactive
// - port direction resets to all ones, zero drives
// - pwm cycle match activates output, selects duty
// - pwm duty match deactivates output, selects cycle
// - transfer needs three count clocks after write
package timer_pkg;
  localparam logic [15:0] port4_direction_addr    = 16'hff24;
  localparam logic [15:0] timer_mode_control_addr = 16'hff70;
  localparam logic [15:0] cycle_compare_addr      = 16'hff71;
  localparam logic [15:0] duty_compare_addr       = 16'hff72;
  localparam logic [15:0] port4_latch_addr        = 16'hff04;

  localparam logic [7:0] port4_direction_reset    = 8'hff;
  localparam logic [7:0] byte_reset               = 8'h00;

  localparam int enable_bit       = 7;
  localparam int clock_sel_hi     = 6;
  localparam int clock_sel_lo     = 4;
  localparam int mode_hi          = 3;
  localparam int mode_lo          = 2;
  localparam int level_bit        = 1;
  localparam int gate_bit         = 0;
  localparam int timer_pin        = 2;

  localparam logic [1:0] mode_interval = 2'b00;
  localparam logic [1:0] mode_pwm      = 2'b10;

  localparam logic [2:0] clk_div1    = 3'b000;
  localparam logic [2:0] clk_div4    = 3'b001;
  localparam logic [2:0] clk_div16   = 3'b010;
  localparam logic [2:0] clk_div64   = 3'b011;
  localparam logic [2:0] clk_div4096 = 3'b100;
  localparam logic [2:0] clk_low_osc = 3'b101;

  localparam int prescale_width  = 12;
  localparam int low_osc_div_width = 7;
  localparam int transfer_guard  = 3;

  typedef enum logic [1:0] {
    cmp_cycle = 2'b01,
    cmp_duty  = 2'b10
  } compare_sel_t;
endpackage : timer_pkg

/* rtl/tick_if.sv */
// count tick carrier between the prescaler and the timer core
interface tick_if;
  logic       tick;
  logic [2:0] clock_select;
  logic       run;

  modport source (output tick, input clock_select, input run);
  modport sink   (input tick, output clock_select, output run);
endinterface : tick_if

/* rtl/tick_gen.sv */
// count tick generator: peripheral clock prescaler and low speed osc divider
module tick_gen (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic low_speed_osc_clock,
  tick_if.source    tk
);
  import timer_pkg::*;

  logic [prescale_width-1:0]    prescale;
  logic [low_osc_div_width-1:0] osc_div;
  logic [2:0]                   osc_sync;
  logic                         osc_level;
  logic                         osc_rise;
  logic [prescale_width-1:0]    prescale_next;

  function automatic logic all_ones(input logic [prescale_width-1:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < prescale_width; i++) begin
      if (i < n && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : all_ones

  assign prescale_next = prescale + 1'b1;

  // prescaler restarts on stop so the first tick lands within one count clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= '0;
    end else if (clk_en) begin
      if (!tk.run) begin
        prescale <= '0;
      end else begin
        prescale <= prescale_next;
      end
    end
  end

  // oscillator pin passes three flops; a rise counts once second and third agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync  <= 3'b000;
      osc_level <= 1'b0;
    end else if (clk_en) begin
      osc_sync <= {osc_sync[1:0], low_speed_osc_clock};
      if (osc_sync[2] == osc_sync[1]) begin
        osc_level <= osc_sync[2];
      end
    end
  end

  assign osc_rise = (osc_sync[2] == osc_sync[1]) && osc_sync[2] && !osc_level;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_div <= '0;
    end else if (clk_en) begin
      if (!tk.run) begin
        osc_div <= '0;
      end else if (osc_rise) begin
        osc_div <= osc_div + 1'b1;
      end
    end
  end

  always_comb begin
    unique case (tk.clock_select)
      clk_div1:    tk.tick = 1'b1;
      clk_div4:    tk.tick = all_ones(prescale, 2);
      clk_div16:   tk.tick = all_ones(prescale, 4);
      clk_div64:   tk.tick = all_ones(prescale, 6);
      clk_div4096: tk.tick = all_ones(prescale, 12);
      clk_low_osc: tk.tick = osc_rise && (&osc_div);
      default:     tk.tick = 1'b0;
    endcase
  end
endmodule : tick_gen

/* verification/timer_h_monitor.sv */
// assertion checker on the timer_h ports
module timer_h_monitor
  import timer_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        low_speed_osc_clock,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_write,
  input wire logic        bus_read,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        timer_interrupt_request,
  input wire logic        timer_output,
  input wire logic        port_pin2,
  input wire logic        port_pin2_oe
);
  logic [7:0] mode_q;
  logic [7:0] dir_q;
  logic       en;
  logic       irq;
  logic       lvl;
  logic       gate;
  logic [1:0] md;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) mode_q <= byte_reset;
    else if (clk_en && bus_write && bus_addr == timer_mode_control_addr) mode_q <= bus_wdata;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) dir_q <= port4_direction_reset;
    else if (clk_en && bus_write && bus_addr == port4_direction_addr) dir_q <= bus_wdata;
  end
  assign en   = mode_q[enable_bit];
  assign lvl  = mode_q[level_bit];
  assign gate = mode_q[gate_bit];
  assign md   = mode_q[mode_hi:mode_lo];
  assign irq  = timer_interrupt_request;
  ctrl_readback_a: assert property ($past(clk_en && bus_read && bus_addr == timer_mode_control_addr, 2)
    |-> bus_rdata == $past(mode_q, 2)) else $error("mode register readback wrong");
  dir_readback_a: assert property ($past(clk_en && bus_read && bus_addr == port4_direction_addr, 2)
    |-> bus_rdata == $past(dir_q, 2)) else $error("direction readback wrong");
  pin_enable_a: assert property (port_pin2_oe == !dir_q[timer_pin]) else $error("pin enable wrong");
  irq_enabled_a: assert property (irq |-> $past(en)) else $error("request while stopped");
  stop_output_a: assert property ((!en && $stable(mode_q))[*4] |-> timer_output == lvl)
    else $error("stopped output not at default level");
  gate_off_a: assert property ((en && !gate && $stable(mode_q))[*4] |-> timer_output == lvl)
    else $error("gated output not at default level");
  irq_pulse_a: assert property (irq && mode_q[6:4] != clk_div1 |=> !irq)
    else $error("request longer than one cycle");
  square_toggle_a: assert property (irq && en && gate && md == mode_interval ##1 en
    |-> timer_output != $past(timer_output)) else $error("no toggle on match");
  pwm_active_a: assert property (irq && en && gate && md == mode_pwm ##1 en
    |-> timer_output != lvl) else $error("output not active after cycle match");
  cover property (irq && md == mode_interval);
  cover property (irq && md == mode_pwm);
  cover property ($fell(en));
endmodule : timer_h_monitor

bind timer_h timer_h_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .low_speed_osc_clock(low_speed_osc_clock), .bus_addr(bus_addr), .bus_write(bus_write),
  .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .timer_interrupt_request(timer_interrupt_request), .timer_output(timer_output),
  .port_pin2(port_pin2), .port_pin2_oe(port_pin2_oe));

/* verification/timer_h_tb_top.sv */
// self-checking bench for timer_h
module timer_h_tb_top
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        low_speed_osc_clock = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_write = 1'b0;
  logic        bus_read = 1'b0;
  logic [7:0]  bus_wdata = 8'h00;
  logic [7:0]  bus_rdata;
  logic        timer_interrupt_request;
  logic        timer_output;
  logic        port_pin2;
  logic        port_pin2_oe;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  always #5 clk_sys = ~clk_sys;
  // slow oscillator, 20 system clocks a period
  always #100 low_speed_osc_clock = ~low_speed_osc_clock;
  always @(posedge clk_sys) cyc <= cyc + 1;
  timer_h DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .low_speed_osc_clock(low_speed_osc_clock), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .timer_interrupt_request(timer_interrupt_request), .timer_output(timer_output),
    .port_pin2(port_pin2), .port_pin2_oe(port_pin2_oe));
  function automatic logic [7:0] md(input logic e, input logic [2:0] c, input logic [1:0] m,
                                    input logic l, input logic g);
    return {e, c, m, l, g};
  endfunction : md
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = d;
    bus_write = 1'b1;
    @(negedge clk_sys);
    bus_write = 1'b0;
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    bus_addr = a;
    bus_read = 1'b1;
    @(negedge clk_sys);
    bus_read = 1'b0;
    @(negedge clk_sys);
    chk(bus_rdata, e);
  endtask : rdc
  task automatic wait_irq(output int t);
    for (int i = 0; i < 20000; i++) begin
      @(negedge clk_sys);
      if (timer_interrupt_request === 1'b1) begin
        t = cyc;
        return;
      end
    end
    n_mismatch++;
    $display("[FAIL] %0t no interrupt request", $time);
    report_and_stop;
  endtask : wait_irq
  task automatic highs(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (timer_output === 1'b1) h++;
    end
  endtask : highs
  task automatic t_reset;
    chk(port_pin2_oe, 1'b0);
    rdc(port4_direction_addr, port4_direction_reset);
    rdc(timer_mode_control_addr, byte_reset);
    rdc(port4_direction_addr, port4_direction_reset);
    rdc(cycle_compare_addr, byte_reset);
    rdc(port4_direction_addr, port4_direction_reset);
    rdc(duty_compare_addr, byte_reset);
    rdc(port4_direction_addr, port4_direction_reset);
    rdc(16'hff00, 8'h00);
  endtask : t_reset
  task automatic t_rw;
    wr(cycle_compare_addr, 8'ha5);
    wr(duty_compare_addr, 8'h3c);
    wr(timer_mode_control_addr, md(0, clk_low_osc, mode_pwm, 1, 0));
    rdc(cycle_compare_addr, 8'ha5);
    rdc(duty_compare_addr, 8'h3c);
    rdc(timer_mode_control_addr, 8'h5a);
    wr(timer_mode_control_addr, 8'h00);
  endtask : t_rw
  task automatic t_square;
    int s;
    int t;
    int h;
    wr(duty_compare_addr, 8'h01);
    wr(cycle_compare_addr, 8'h03);
    wr(timer_mode_control_addr, md(0, clk_div1, mode_interval, 0, 1));
    wr(timer_mode_control_addr, md(1, clk_div1, mode_interval, 0, 1));
    s = cyc;
    wait_irq(t);
    // one masked tick, then counter values 0 to 3
    chk(t - s, 5);
    highs(8, h);
    chk(h, 4);
    // clock enable low must freeze the running square wave
    @(negedge clk_sys);
    clk_en = 1'b0;
    h = timer_output;
    repeat (20) @(negedge clk_sys);
    chk(timer_output, h);
    clk_en = 1'b1;
    wr(timer_mode_control_addr, md(0, clk_div1, mode_interval, 0, 1));
    highs(4, h);
    chk({timer_output, timer_interrupt_request}, 2'b00);
    wr(timer_mode_control_addr, md(0, clk_div1, mode_interval, 1, 1));
    highs(3, h);
    chk(timer_output, 1'b1);
  endtask : t_square
  task automatic t_pwm;
    int t0;
    int t1;
    int h;
    wr(cycle_compare_addr, 8'h04);
    wr(duty_compare_addr, 8'h01);
    wr(timer_mode_control_addr, md(0, clk_div1, mode_pwm, 0, 1));
    wr(timer_mode_control_addr, md(1, clk_div1, mode_pwm, 0, 1));
    wait_irq(t0);
    wait_irq(t1);
    chk(t1 - t0, 5);
    highs(5, h);
    chk(h, 2);
    wr(duty_compare_addr, 8'h03);
    repeat (3) wait_irq(t0);
    highs(5, h);
    chk(h, 4);
  endtask : t_pwm
  task automatic t_pin;
    // stopped with default level high, so the pin must follow a steady 1
    wr(timer_mode_control_addr, md(0, clk_div1, mode_pwm, 0, 1));
    wr(timer_mode_control_addr, md(0, clk_div1, mode_pwm, 1, 1));
    wr(port4_direction_addr, 8'hfb);
    chk(port_pin2_oe, 1'b1);
    wr(port4_latch_addr, 8'h00);
    repeat (5) begin
      @(negedge clk_sys);
      chk(port_pin2, 1'b1);
    end
    wr(port4_latch_addr, 8'h04);
    chk(port_pin2, 1'b0);
    wr(port4_direction_addr, 8'hff);
    chk(port_pin2_oe, 1'b0);
  endtask : t_pin
  task automatic t_intervals;
    int divs[6] = '{1, 4, 16, 64, 4096, 2560};
    int t0;
    int t1;
    for (int c = 0; c < 6; c++) begin
      // gate alternates so both gated and ungated runs are seen
      wr(cycle_compare_addr, 8'h02);
      wr(timer_mode_control_addr, md(0, c[2:0], mode_interval, 1, c[0]));
      wr(timer_mode_control_addr, md(1, c[2:0], mode_interval, 1, c[0]));
      wait_irq(t0);
      wait_irq(t1);
      chk(t1 - t0, 3 * divs[c]);
      wr(timer_mode_control_addr, md(0, c[2:0], mode_interval, 1, c[0]));
    end
  endtask : t_intervals
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset;
    t_rw;
    t_square;
    t_pwm;
    t_pin;
    t_intervals;
    report_and_stop;
  end
endmodule : timer_h_tb_top
